//--- sfc_top.sv
// Command and status front end of a serial flash, device side.
`timescale 1ns/1ns
`default_nettype none

// Function
// (RULE1) Sectors are 4 KB, sixteen per block
// (RULE2) Unknown command: standby, output off till reselect
// (RULE3) Valid command stays active until deselect
// (RULE4) Sample input on rise, drive output on fall
// (RULE5) Host uses mode 0 or 3
// (RULE6) Read-type commands may end after any bit
// (RULE7) Write-type commands need exact byte boundary
// (RULE8) Array access ignored while a cycle runs
// (RULE9) Set-latch command sets the write latch
// (RULE10) Lone clear-latch command clears the latch
// (RULE11) Latch cleared at reset and completions
// (RULE12) Identification shifts out three bytes
// (RULE13) Identification not decoded while busy
// (RULE14) Status readable anytime, repeated while selected
// (RULE15) Host polls busy before new commands
// (RULE16) Status bit 0 is busy
// (RULE17) Latch clear refuses program, erase, status write
// (RULE18) Protected-area program or erase is ignored
// (RULE19) Bits 5..2 are protect level, status-written
// (RULE20) Chip erase only with protect level zero
// (RULE21) Lock flag with protect pin low refuses writes; code blocks only status writes, program and erase still run
// (RULE22) Status write keeps bits 6, 1, 0
// (RULE23) Status write cycle busy, then clears latch
// (RULE24) Hardware lock left only after pin high
// (RULE25) Command codes, received MSB first
// (RULE26) Protect level to range from parameter table
module sfc_top #(
  parameter int unsigned      WR_STAT_CYCLES   = sfc_pkg::DEF_WR_STAT_CYC,
  parameter int unsigned      PROG_CYCLES      = sfc_pkg::DEF_PROG_CYC,
  parameter int unsigned      ERASE_CYCLES     = sfc_pkg::DEF_ERASE_CYC,
  // Identification bytes; the values are arbitrary.
  parameter logic [7:0]       MAKER_ID         = 8'h5A,
  parameter logic [7:0]       MEM_TYPE_ID      = 8'hA5,
  parameter logic [7:0]       DEVICE_ID        = 8'h3C,
  // Lowest protected address for each protect level, level 0 at bit 0.
  parameter logic [383:0]     PROT_FLOOR_TABLE = '0
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic si,
  input  wire logic wp_n,
  output var  logic so_out,
  output var  logic so_oe,
  output var  logic busy
);
  import sfc_pkg::*;

  // ==========================================================================
  // Functions.

  function automatic logic is_known(input logic [7:0] c);
    logic k;
    k = 1'b0;
    case (c)
      SET_WRITE_LATCH_CMD, CLEAR_WRITE_LATCH_CMD, READ_JEDEC_ID_CMD,
      READ_STATUS_CMD, WRITE_STATUS_CMD, READ_DATA_CMD, FAST_READ_CMD,
      SMALL_REGION_WIPE_CMD, LARGE_REGION_WIPE_CMD, CHIP_WIPE_CMD_A,
      CHIP_WIPE_CMD_B, PAGE_PROGRAM_CMD, ENTER_SLEEP_CMD,
      WAKE_FROM_SLEEP_CMD, READ_MAKER_DEV_ID_CMD, ENTER_OTP_AREA_CMD,
      LEAVE_OTP_AREA_CMD, READ_SECURITY_CMD, LOCK_SECURITY_CMD: k = 1'b1;
      default: k = 1'b0;
    endcase
    return k;
  endfunction : is_known

  // While busy only the status read is decoded; all else is standby.
  function automatic sfc_link_e dispatch(input logic [7:0] c,
                                         input logic       bsy);
    sfc_link_e s;
    s = LK_IGNORE;
    if (c == READ_STATUS_CMD) begin
      s = LK_STAT; // [RULE14]
    end else if (bsy) begin
      s = LK_IGNORE; // [RULE8] [RULE13]
    end else if (c == READ_JEDEC_ID_CMD) begin
      s = LK_ID;
    end else if (is_known(c)) begin
      s = LK_ARG; // [RULE3]
    end
    return s;
  endfunction : dispatch

  function automatic logic [11:0] sector_of(input logic [23:0] a);
    return a[ADDR_W-1:SECTOR_LSB]; // [RULE1]
  endfunction : sector_of

  function automatic logic [23:0] floor_of(input logic [3:0] lvl);
    return PROT_FLOOR_TABLE[lvl*ADDR_W +: ADDR_W];
  endfunction : floor_of

  // Protection covers the top of the array down to the level's floor.
  function automatic logic is_prot(input logic [3:0]  lvl,
                                   input logic [23:0] last);
    return (lvl != PROT_LVL_RST) && (last >= floor_of(lvl)); // [RULE26]
  endfunction : is_prot

  // ==========================================================================
  // Link domain, cleared by the frame's own select.
  logic       frame_rst_n;
  sfc_link_e  lk_state_q;
  sfc_link_e  lk_state_d;
  logic [2:0] fbit_q;
  logic [2:0] fbit_d;
  logic [2:0] fbyte_q;
  logic [2:0] fbyte_d;
  logic [6:0] sh_q;
  logic [4:0] obit_q;
  logic [4:0] obit_d;
  logic [7:0] cmd_full;
  logic       byte_end;
  logic       cmd_end;
  logic       arg_take;
  logic [7:0] lat_cmd_d;
  logic [7:0] stat_lnk_q;

  assign frame_rst_n = nrst & ~cs_n; // [RULE2] [RULE3]
  assign cmd_full    = {sh_q, si}; // [RULE25]
  assign byte_end    = (fbit_q == 3'h7);
  assign cmd_end     = byte_end && (lk_state_q == LK_CMD);
  assign fbit_d      = fbit_q + 3'h1;
  assign fbyte_d     = (byte_end && fbyte_q != LEN_SAT) ?
                       fbyte_q + 3'h1 : fbyte_q;
  assign lk_state_d  = cmd_end ? dispatch(cmd_full, stat_lnk_q[ST_BUSY_BIT])
                               : lk_state_q;
  assign obit_d      = (lk_state_q == LK_ID && obit_q != ID_LAST + 5'h1) ?
                       obit_q + 5'h1 :
                       (lk_state_q == LK_STAT) ? {2'h0, obit_q[2:0] + 3'h1}
                                               : obit_q;
  assign arg_take    = (lk_state_q == LK_ARG) && (fbyte_q != 3'h0) &&
                       (fbyte_q < LEN_ADDR);
  assign lat_cmd_d   = (lk_state_d == LK_IGNORE) ? NO_CMD : cmd_full;

  always_ff @(posedge sclk or negedge frame_rst_n) begin // [RULE4]
    if (!frame_rst_n) begin
      lk_state_q <= LK_CMD;
      fbit_q     <= 3'h0;
      fbyte_q    <= 3'h0;
      sh_q       <= 7'h00;
      obit_q     <= 5'h00;
    end else begin
      lk_state_q <= lk_state_d;
      fbit_q     <= fbit_d;
      fbyte_q    <= fbyte_d;
      sh_q       <= {sh_q[5:0], si};
      obit_q     <= obit_d;
    end
  end

  // ==========================================================================
  // Link domain, frame snapshot kept across deselect for the core.
  logic [7:0]  lat_cmd_q;
  logic [23:0] lat_arg_q;
  logic [2:0]  lat_phase_q;
  logic [2:0]  lat_bytes_q;
  logic        lat_tog_q;
  logic        req_s1_q;
  logic        req_s2_q;
  logic        ack_q;
  logic [7:0]  stat_hold_q;
  logic        req_tog_q;

  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      lat_cmd_q   <= NO_CMD;
      lat_arg_q   <= 24'h000000;
      lat_phase_q <= 3'h0;
      lat_bytes_q <= 3'h0;
      lat_tog_q   <= 1'b0;
      req_s1_q    <= 1'b0;
      req_s2_q    <= 1'b0;
      ack_q       <= 1'b0;
      stat_lnk_q  <= 8'h00;
    end else begin
      // Clock edges while deselected, as a mode 3 host may give, start
      // no frame and leave the snapshot alone.
      if (!cs_n && fbit_q == 3'h0 && fbyte_q == 3'h0) begin // [RULE5]
        lat_tog_q <= ~lat_tog_q;
      end
      if (cmd_end) begin
        lat_cmd_q <= lat_cmd_d;
      end
      if (!cs_n && lk_state_q != LK_IGNORE) begin // [RULE2]
        lat_phase_q <= fbit_d; // [RULE7]
        lat_bytes_q <= fbyte_d;
      end
      if (arg_take) begin
        lat_arg_q <= {lat_arg_q[22:0], si};
      end
      req_s1_q <= req_tog_q;
      req_s2_q <= req_s1_q;
      if (req_s2_q != ack_q) begin
        stat_lnk_q <= stat_hold_q;
        ack_q      <= req_s2_q;
      end
    end
  end

  // ==========================================================================
  // Serial output, driven on the falling clock edge.
  logic [23:0] id_word;
  logic        id_on;
  logic        so_d;
  logic        oe_d;

  assign id_word = {MAKER_ID, MEM_TYPE_ID, DEVICE_ID}; // [RULE12]
  assign id_on   = (lk_state_q == LK_ID) && (obit_q <= ID_LAST);
  assign so_d    = id_on ? id_word[ID_LAST - obit_q] :
                   (lk_state_q == LK_STAT) ?
                   stat_lnk_q[3'h7 - obit_q[2:0]] : 1'b0; // [RULE14]
  assign oe_d    = id_on || (lk_state_q == LK_STAT); // [RULE2] [RULE6]

  always_ff @(negedge sclk or negedge frame_rst_n) begin // [RULE4] [RULE5]
    if (!frame_rst_n) begin
      so_out <= 1'b0;
      so_oe  <= 1'b0;
    end else begin
      so_out <= so_d;
      so_oe  <= oe_d;
    end
  end

  // ==========================================================================
  // Core domain: pin and crossing synchronisers.
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_old_q;
  logic tog_s1_q;
  logic tog_s2_q;
  logic tog_seen_q;
  logic wp_s1_q;
  logic wp_s2_q;
  logic ack_s1_q;
  logic ack_s2_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cs_s1_q    <= 1'b1;
      cs_s2_q    <= 1'b1;
      cs_old_q   <= 1'b1;
      tog_s1_q   <= 1'b0;
      tog_s2_q   <= 1'b0;
      tog_seen_q <= 1'b0;
      wp_s1_q    <= 1'b1;
      wp_s2_q    <= 1'b1;
      ack_s1_q   <= 1'b0;
      ack_s2_q   <= 1'b0;
    end else begin
      cs_s1_q  <= cs_n;
      cs_s2_q  <= cs_s1_q;
      cs_old_q <= cs_s2_q;
      tog_s1_q <= lat_tog_q;
      tog_s2_q <= tog_s1_q;
      wp_s1_q  <= wp_n;
      wp_s2_q  <= wp_s1_q;
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
      if (cs_s2_q && !cs_old_q) begin
        tog_seen_q <= tog_s2_q;
      end
    end
  end

  // ==========================================================================
  // Core domain: command execution at deselect.
  logic        wel_q;
  logic        busy_q;
  logic [3:0]  lvl_q;
  logic        lock_q;
  logic        hwl_q;
  sfc_op_e     op_q;
  logic [31:0] cnt_q;
  logic [3:0]  new_lvl_q;
  logic        new_lock_q;
  logic        commit;
  logic        aligned;
  logic        wr_block;
  logic        go_set_wl;
  logic        go_clr_wl;
  logic        go_wr_stat;
  logic        go_small;
  logic        go_large;
  logic        go_chip;
  logic        go_prog;
  logic        go_array;
  logic        done;
  logic [23:0] sect_last;
  logic [7:0]  stat_live;

  assign commit    = cs_s2_q && !cs_old_q && (tog_s2_q != tog_seen_q) &&
                     !busy_q; // [RULE8]
  assign aligned   = (lat_phase_q == 3'h0); // [RULE7]
  assign wr_block  = hwl_q || (lock_q && !wp_s2_q); // [RULE21] [RULE24]
  assign sect_last = {sector_of(lat_arg_q), 12'h000} | SECTOR_MASK;
  assign go_set_wl = commit && aligned && lat_bytes_q == LEN_LONE &&
                     lat_cmd_q == SET_WRITE_LATCH_CMD; // [RULE9]
  assign go_clr_wl = commit && aligned && lat_bytes_q == LEN_LONE &&
                     lat_cmd_q == CLEAR_WRITE_LATCH_CMD; // [RULE10]
  assign go_wr_stat = commit && aligned && lat_bytes_q == LEN_WR_STAT &&
                      lat_cmd_q == WRITE_STATUS_CMD && wel_q &&
                      !wr_block; // [RULE17] [RULE21]
  assign go_small  = lat_cmd_q == SMALL_REGION_WIPE_CMD &&
                     lat_bytes_q == LEN_ADDR &&
                     !is_prot(lvl_q, sect_last); // [RULE1] [RULE18]
  assign go_large  = lat_cmd_q == LARGE_REGION_WIPE_CMD &&
                     lat_bytes_q == LEN_ADDR &&
                     !is_prot(lvl_q, lat_arg_q | BLOCK_MASK); // [RULE18]
  assign go_chip   = (lat_cmd_q == CHIP_WIPE_CMD_A ||
                      lat_cmd_q == CHIP_WIPE_CMD_B) &&
                     lat_bytes_q == LEN_LONE &&
                     lvl_q == PROT_LVL_RST; // [RULE20]
  assign go_prog   = lat_cmd_q == PAGE_PROGRAM_CMD &&
                     lat_bytes_q >= LEN_PROG_MIN &&
                     !is_prot(lvl_q, lat_arg_q); // [RULE18]
  assign go_array  = commit && aligned && wel_q &&
                     (go_small || go_large || go_chip || go_prog); // [RULE17]
  assign done      = busy_q && (cnt_q == 32'h0);
  assign stat_live = {lock_q, 1'b0, lvl_q, wel_q, busy_q}; // [RULE16]

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wel_q      <= 1'b0; // [RULE11]
      busy_q     <= 1'b0;
      lvl_q      <= PROT_LVL_RST;
      lock_q     <= LOCK_RST;
      op_q       <= OP_IDLE;
      cnt_q      <= 32'h0;
      new_lvl_q  <= PROT_LVL_RST;
      new_lock_q <= LOCK_RST;
    end else begin
      if (go_set_wl) begin
        wel_q <= 1'b1; // [RULE9]
      end else if (go_clr_wl) begin
        wel_q <= 1'b0; // [RULE10] [RULE11]
      end
      if (go_wr_stat) begin
        busy_q     <= 1'b1; // [RULE23]
        op_q       <= OP_WR_STAT;
        cnt_q      <= 32'(WR_STAT_CYCLES - 1);
        new_lvl_q  <= lat_arg_q[ST_PL_MSB:ST_PL_LSB]; // [RULE19] [RULE22]
        new_lock_q <= lat_arg_q[ST_LOCK_BIT];
      end else if (go_array) begin
        busy_q <= 1'b1; // [RULE16]
        op_q   <= OP_ARRAY;
        cnt_q  <= go_prog ? 32'(PROG_CYCLES - 1) : 32'(ERASE_CYCLES - 1);
      end else if (done) begin
        busy_q <= 1'b0; // [RULE23]
        wel_q  <= 1'b0; // [RULE11]
        op_q   <= OP_IDLE;
        if (op_q == OP_WR_STAT) begin
          lvl_q  <= new_lvl_q; // [RULE19]
          lock_q <= new_lock_q;
        end
      end else if (busy_q) begin
        cnt_q <= cnt_q - 32'h1;
      end
    end
  end

  // Hardware lock: entered with lock flag and pin low, left on pin high.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hwl_q <= 1'b0;
    end else if (wp_s2_q) begin
      hwl_q <= 1'b0; // [RULE24]
    end else if (lock_q) begin
      hwl_q <= 1'b1; // [RULE21]
    end
  end

  // Status word handed to the link domain by a toggle handshake.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stat_hold_q <= 8'h00;
      req_tog_q   <= 1'b0;
      busy        <= 1'b0;
    end else begin
      busy <= busy_q;
      if (req_tog_q == ack_s2_q && stat_live != stat_hold_q) begin
        stat_hold_q <= stat_live;
        req_tog_q   <= ~req_tog_q;
      end
    end
  end

endmodule : sfc_top

`default_nettype wire

//--- sfc_pkg.sv
// Constants, command codes and state types of the serial flash front end.
package sfc_pkg;

  // ==========================================================================
  // Command codes, first byte of a frame, most significant bit first.
  localparam logic [7:0] SET_WRITE_LATCH_CMD   = 8'h06;
  localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
  localparam logic [7:0] READ_JEDEC_ID_CMD     = 8'h9F;
  localparam logic [7:0] READ_STATUS_CMD       = 8'h05;
  localparam logic [7:0] WRITE_STATUS_CMD      = 8'h01;
  localparam logic [7:0] READ_DATA_CMD         = 8'h03;
  localparam logic [7:0] FAST_READ_CMD         = 8'h0B;
  localparam logic [7:0] SMALL_REGION_WIPE_CMD = 8'h20;
  localparam logic [7:0] LARGE_REGION_WIPE_CMD = 8'hD8;
  localparam logic [7:0] CHIP_WIPE_CMD_A       = 8'h60;
  localparam logic [7:0] CHIP_WIPE_CMD_B       = 8'hC7;
  localparam logic [7:0] PAGE_PROGRAM_CMD      = 8'h02;
  localparam logic [7:0] ENTER_SLEEP_CMD       = 8'hB9;
  localparam logic [7:0] WAKE_FROM_SLEEP_CMD   = 8'hAB;
  localparam logic [7:0] READ_MAKER_DEV_ID_CMD = 8'h90;
  localparam logic [7:0] ENTER_OTP_AREA_CMD    = 8'hB1;
  localparam logic [7:0] LEAVE_OTP_AREA_CMD    = 8'hC1;
  localparam logic [7:0] READ_SECURITY_CMD     = 8'h2B;
  localparam logic [7:0] LOCK_SECURITY_CMD     = 8'h2F;
  // Latched in place of a refused or unknown command byte.
  localparam logic [7:0] NO_CMD                = 8'h00;

  // ==========================================================================
  // Status byte layout and reset values.
  localparam int         ST_BUSY_BIT  = 0;
  localparam int         ST_WL_BIT    = 1;
  localparam int         ST_PL_LSB    = 2;
  localparam int         ST_PL_MSB    = 5;
  localparam int         ST_LOCK_BIT  = 7;
  localparam logic [3:0] PROT_LVL_RST = 4'h0;
  localparam logic       LOCK_RST     = 1'b0;

  // ==========================================================================
  // Address map and frame lengths in bytes.
  localparam int          ADDR_W       = 24;
  localparam int          SECTOR_LSB   = 12;
  localparam int          BLOCK_LSB    = 16;
  localparam logic [23:0] SECTOR_MASK  = 24'h000FFF;
  localparam logic [23:0] BLOCK_MASK   = 24'h00FFFF;
  localparam int          ID_BITS      = 24;
  localparam logic [4:0]  ID_LAST      = 5'h17;
  localparam logic [2:0]  LEN_LONE     = 3'h1;
  localparam logic [2:0]  LEN_WR_STAT  = 3'h2;
  localparam logic [2:0]  LEN_ADDR     = 3'h4;
  localparam logic [2:0]  LEN_PROG_MIN = 3'h5;
  localparam logic [2:0]  LEN_SAT      = 3'h7;

  // ==========================================================================
  // Default self-timed cycle lengths in mclk cycles.
  localparam int unsigned DEF_WR_STAT_CYC = 1000;
  localparam int unsigned DEF_PROG_CYC    = 1000;
  localparam int unsigned DEF_ERASE_CYC   = 1000;

  typedef enum logic [2:0] {LK_CMD, LK_ID, LK_STAT, LK_ARG, LK_IGNORE}
    sfc_link_e;
  typedef enum logic [1:0] {OP_IDLE, OP_WR_STAT, OP_ARRAY} sfc_op_e;

endpackage : sfc_pkg

//--- sfc_top_chk.sv
// Port checker for the serial flash command and status front end.
`timescale 1ns/1ns
`default_nettype none
module sfc_chk #(
  parameter int unsigned WR_STAT_CYCLES = sfc_pkg::DEF_WR_STAT_CYC,
  parameter int unsigned PROG_CYCLES    = sfc_pkg::DEF_PROG_CYC,
  parameter int unsigned ERASE_CYCLES   = sfc_pkg::DEF_ERASE_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  input wire logic so_out,
  input wire logic so_oe,
  input wire logic busy
);
  import sfc_pkg::*;
  // ==========================================================================
  // Frame bit counter, command capture and busy run length.
  logic [5:0]  bit_q;
  logic [7:0]  cmd_q;
  logic [15:0] run_q;
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_q <= 6'h00;
      cmd_q <= 8'h00;
    end else begin
      if (bit_q != 6'h3F) bit_q <= bit_q + 6'h01;
      if (bit_q < 6'h08) cmd_q <= {cmd_q[6:0], si};
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) run_q <= 16'h0000;
    else run_q <= busy ? run_q + 16'h0001 : 16'h0000;
  end
  // ==========================================================================
  // Core clock domain.
  chk_oe_deselect: assert property (
    @(posedge mclk) disable iff (!nrst) cs_n |-> !so_oe)
    else $error("so_oe high while deselected");
  chk_busy_length: assert property (
    @(posedge mclk) disable iff (!nrst) $fell(busy) |->
      ({16'h0000, run_q} == WR_STAT_CYCLES || {16'h0000, run_q} ==
       PROG_CYCLES || {16'h0000, run_q} == ERASE_CYCLES))
    else $error("busy window has the wrong length");
  chk_out_on_fall: assert property (
    @(posedge mclk) disable iff (!nrst)
      (!cs_n && so_oe && $changed(so_out)) |-> !sclk)
    else $error("so_out changed away from a falling sclk");
  chk_busy_deselected: assert property (
    @(posedge mclk) disable iff (!nrst) $rose(busy) |-> cs_n && $past(cs_n))
    else $error("busy started inside a frame");
  chk_reset_quiet: assert property (
    @(posedge mclk) disable iff (!nrst) $rose(nrst) |-> !busy && !so_oe)
    else $error("outputs active right after reset");
  // ==========================================================================
  // Link clock domain, reset by deselect.
  chk_no_early_out: assert property (
    @(posedge sclk) disable iff (cs_n) so_oe |-> bit_q >= 6'h08)
    else $error("output driven before the command byte ended");
  chk_status_drive: assert property (
    @(posedge sclk) disable iff (cs_n)
      (cmd_q == READ_STATUS_CMD && bit_q >= 6'h08) |-> so_oe)
    else $error("status read not driven");
  chk_status_repeat: assert property (
    @(posedge sclk) disable iff (cs_n)
      (cmd_q == READ_STATUS_CMD && bit_q >= 6'h10) |->
      so_out == $past(so_out, 8))
    else $error("status byte not repeated");
  chk_id_stop: assert property (
    @(posedge sclk) disable iff (cs_n)
      (cmd_q == READ_JEDEC_ID_CMD && bit_q == 6'h20) |-> !so_oe)
    else $error("identification longer than three bytes");
  chk_other_quiet: assert property (
    @(posedge sclk) disable iff (cs_n) (bit_q >= 6'h08 && cmd_q !=
      READ_STATUS_CMD && cmd_q != READ_JEDEC_ID_CMD) |-> !so_oe)
    else $error("output driven for a command without data");
endmodule : sfc_chk
bind sfc_top sfc_chk #(
  .WR_STAT_CYCLES(WR_STAT_CYCLES),
  .PROG_CYCLES   (PROG_CYCLES),
  .ERASE_CYCLES  (ERASE_CYCLES)
) u_chk (.mclk(mclk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .si(si),
  .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe), .busy(busy));
`default_nettype wire

//--- sfc_host_model.sv
// Serial host controller model that frames commands into the front end.
`timescale 1ns/1ns
`default_nettype none
module sfc_host_model (
  output var  logic sclk,
  output var  logic cs_n,
  output var  logic si,
  input  wire logic so_out,
  input  wire logic so_oe
);
  localparam int HALF = 6;
  logic mode3;
  wire  logic so_line;
  // An undriven output reads as high impedance and never matches data.
  assign so_line = so_oe ? so_out : 1'bz;
  // A select pulse inside reset gives every frame counter a defined start.
  initial begin
    mode3 = 1'b0;
    sclk  = 1'b0;
    cs_n  = 1'b0;
    si    = 1'b0;
    #3;
    cs_n  = 1'b1;
  end
  task automatic set_mode(input logic m3);
    mode3 = m3;
    sclk  = m3;
    #(HALF);
  endtask : set_mode
  // Sends ntx bits of tx MSB first, then clocks nrx bits back in.
  task automatic xfer(input logic [39:0] tx, input int ntx, input int nrx,
                      output logic [23:0] rx, output logic oe_all);
    rx     = 24'h000000;
    oe_all = 1'b1;
    #1;
    cs_n = 1'b0;
    #(HALF);
    for (int i = 0; i < ntx + nrx; i++) begin
      sclk = 1'b0;
      si   = (i < ntx) ? tx[39 - i] : ~si;
      #(HALF);
      if (i >= ntx) begin
        rx     = {rx[22:0], so_line};
        oe_all = oe_all & so_oe;
      end
      sclk = 1'b1;
      #(HALF);
    end
    sclk = mode3;
    #(HALF);
    cs_n = 1'b1;
    #60;
  endtask : xfer
endmodule : sfc_host_model
`default_nettype wire

//--- serial_flash_command_status_tb_top.sv
// Self-checking bench for the serial flash command and status front end.
`timescale 1ns/1ns
`default_nettype none
module serial_flash_command_status_tb_top;
  import sfc_pkg::*;
  localparam int unsigned CYC = 200;
  // Identification bytes; the values are arbitrary.
  localparam logic [23:0] ID = 24'h5AA53C;
  logic        mclk;
  logic        nrst;
  logic        wp_n;
  wire  logic  sclk;
  wire  logic  cs_n;
  wire  logic  si;
  wire  logic  so_out;
  wire  logic  so_oe;
  wire  logic  busy;
  int          num_errors;
  int          comparisons;
  logic [23:0] rx;
  logic        oe;
  logic [7:0]  st;
  sfc_top #(.WR_STAT_CYCLES(CYC), .PROG_CYCLES(CYC), .ERASE_CYCLES(CYC),
    .MAKER_ID(ID[23:16]), .MEM_TYPE_ID(ID[15:8]), .DEVICE_ID(ID[7:0])
  ) u_dut (.mclk(mclk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .si(si),
    .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe), .busy(busy));
  sfc_host_model u_host (.sclk(sclk), .cs_n(cs_n), .si(si),
    .so_out(so_out), .so_oe(so_oe));
  always #2 mclk = ~mclk;
  // ==========================================================================
  // Shared tasks.
  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic frame(input logic [39:0] tx, input int ntx, input int nrx);
    @(negedge mclk);
    u_host.xfer(tx, ntx, nrx, rx, oe);
  endtask : frame
  task automatic status();
    frame({READ_STATUS_CMD, 32'h0}, 8, 8);
    st = rx[7:0];
  endtask : status
  task automatic wait_ready();
    status();
    for (int i = 0; i < 60 && st[0] !== 1'b0; i++) status();
  endtask : wait_ready
  task automatic cmd1(input logic [7:0] c);
    frame({c, 32'h0}, 8, 0);
  endtask : cmd1
  // ==========================================================================
  // Scenarios.
  task automatic t_reset_id();
    check("busy pin", 24'(busy), 24'h0);
    status();
    check("reset status", 24'(st), 24'h0);
    for (int m = 0; m < 2; m++) begin
      u_host.set_mode(m[0]);
      frame({READ_JEDEC_ID_CMD, 32'h0}, 8, 24 + m);
      check("id", rx, m ? {ID[22:0], 1'bz} : ID);
    end
    frame({READ_JEDEC_ID_CMD, 32'h0}, 8, 3);
    check("short id", rx, 24'(ID[23:21]));
    status();
    check("after short id", 24'(st), 24'h0);
  endtask : t_reset_id
  task automatic t_latch();
    cmd1(SET_WRITE_LATCH_CMD);
    status();
    check("latch set", 24'(st), 24'h02);
    frame({CLEAR_WRITE_LATCH_CMD, 32'h0}, 16, 0);
    status();
    check("long clear", 24'(st), 24'h02);
    cmd1(CLEAR_WRITE_LATCH_CMD);
    status();
    check("latch clear", 24'(st), 24'h00);
    frame({SET_WRITE_LATCH_CMD, 32'h0}, 9, 0);
    status();
    check("ragged set", 24'(st), 24'h00);
    frame({8'hFF, 32'h0}, 8, 16);
    check("unknown out", rx, {8'h00, 16'hZZZZ});
    frame({WRITE_STATUS_CMD, 8'h9C, 24'h0}, 16, 0);
    status();
    check("unlatched write", 24'(st), 24'h00);
  endtask : t_latch
  task automatic t_protect();
    u_host.set_mode(1'b0);
    cmd1(SET_WRITE_LATCH_CMD);
    frame({WRITE_STATUS_CMD, 8'hFF, 24'h0}, 16, 0);
    check("busy pin", 24'(busy), 24'h1);
    status();
    check("busy status", 24'(st), 24'h03);
    frame({READ_JEDEC_ID_CMD, 32'h0}, 8, 8);
    check("id when busy", rx, {16'h0, 8'hZZ});
    wait_ready();
    check("new status", 24'(st), 24'hBC);
    frame({READ_STATUS_CMD, 32'h0}, 8, 24);
    check("repeat", rx, 24'hBCBCBC);
    check("repeat drive", 24'(oe), 24'h1);
    cmd1(SET_WRITE_LATCH_CMD);
    frame({SMALL_REGION_WIPE_CMD, 24'h010000, 8'h0}, 32, 0);
    cmd1(CHIP_WIPE_CMD_B);
    check("no erase", 24'(busy), 24'h0);
    status();
    check("kept latch", 24'(st), 24'hBE);
    @(negedge mclk);
    wp_n = 1'b0;
    frame({WRITE_STATUS_CMD, 8'h00, 24'h0}, 16, 0);
    status();
    check("locked", 24'(st), 24'hBE);
    @(negedge mclk);
    wp_n = 1'b1;
    frame({WRITE_STATUS_CMD, 8'h00, 24'h0}, 16, 0);
    wait_ready();
    check("unlocked", 24'(st), 24'h00);
  endtask : t_protect
  task automatic t_erase();
    cmd1(SET_WRITE_LATCH_CMD);
    frame({SMALL_REGION_WIPE_CMD, 24'h010FFF, 8'h0}, 24, 0);
    status();
    check("short erase", 24'(st), 24'h02);
    frame({SMALL_REGION_WIPE_CMD, 24'h010FFF, 8'h0}, 32, 0);
    check("erase busy", 24'(busy), 24'h1);
    frame({READ_DATA_CMD, 24'h010000, 8'h0}, 32, 0);
    check("read in erase", 24'(busy), 24'h1);
    wait_ready();
    check("erase done", 24'(st), 24'h00);
    for (int k = 0; k < 2; k++) begin
      cmd1(SET_WRITE_LATCH_CMD);
      if (k == 0) cmd1(CHIP_WIPE_CMD_A);
      else frame({PAGE_PROGRAM_CMD, 24'h000100, 8'hA5}, 40, 0);
      check("started", 24'(busy), 24'h1);
      wait_ready();
      check("finished", 24'(st), 24'h00);
    end
  endtask : t_erase
  // ==========================================================================
  // Main sequence and watchdog.
  initial begin
    mclk        = 1'b0;
    nrst        = 1'b1;
    wp_n        = 1'b1;
    num_errors  = 0;
    comparisons = 0;
    // Reset falls just after time zero so every reset edge is seen.
    #1;
    nrst = 1'b0;
    repeat (2) @(negedge mclk);
    nrst = 1'b1;
    repeat (3) @(negedge mclk);
    t_reset_id();
    t_latch();
    t_protect();
    t_erase();
    wrap_up();
  end
  initial begin
    #200000;
    num_errors++;
    wrap_up();
  end
endmodule : serial_flash_command_status_tb_top
`default_nettype wire
